//--- sfpi_host.sv
`timescale 1ns/1ps
`default_nettype none

module sfpi_host (
  output logic            sck_o,  // serial clock, still between frames
  output logic            cs_n_o, // select, active low
  output logic      [3:0] d_o,    // line drive values
  output logic      [3:0] oe_o,   // line drive enables
  input  wire logic [3:0] d_i,    // resolved line levels
  output logic            got_o,  // read byte complete
  output logic      [7:0] byte_o  // read byte
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    d_o    = 4'h0;
    oe_o   = 4'h0;
    got_o  = 1'b0;
    byte_o = 8'h00;
  end

  // idle high is mode 3, so a read's first fall already shifts data
  task automatic frame(input logic on, input logic idle);
    sck_o = idle;
    #100 cs_n_o = !on;
    oe_o = 4'h0;
    #200;
  endtask : frame

  task automatic xfer(input int k, input logic rd, input logic [7:0] b);
    logic [7:0] s;
    s = b;
    for (int u = 0; u < 8 / k; u++) begin
      sck_o = 1'b0;
      oe_o  = rd ? 4'h0 : 4'((1 << k) - 1);
      d_o   = 4'(s >> (8 - k));
      s     = s << k;
      #80 sck_o = 1'b1;
      #80;
      if (rd && k == 1) byte_o = {byte_o[6:0], d_i[1]};
      else if (rd) byte_o = 8'((byte_o << k) | (d_i & 4'((1 << k) - 1)));
    end
    // let go of the lines once the last bit is taken
    oe_o = 4'h0;
    if (rd) got_o = 1'b1;
    #20 got_o = 1'b0;
  endtask : xfer
endmodule : sfpi_host

`default_nettype wire

//--- sfpi_pins.sv
`timescale 1ns/1ps
`default_nettype none

module sfpi_pins (
  input  wire logic       clk_i,                 // 50 MHz system clock
  input  wire logic       rst_i,                 // async reset, active high
  input  wire logic       sck_i,                 // serial clock pin
  input  wire logic       cs_n_i,                // select pin, active low
  input  wire logic [3:0] data_i,                // data_line_3..0 pin levels
  output logic      [3:0] data_o,                // data_line_3..0 drive values
  output logic      [3:0] data_oe_o,             // per-line drive enables
  input  wire logic [1:0] bus_width_i,           // sfpi_pkg::SFPI_W_* width
  input  wire logic       tx_drive_i,            // core wants to drive read data
  input  wire logic [7:0] tx_byte_i,             // next byte to shift out
  output logic            tx_take_o,             // tx_byte_i was loaded (pulse)
  output logic      [7:0] rx_byte_o,             // last byte shifted in
  output logic            rx_valid_o,            // rx_byte_o fresh (pulse)
  output logic            selected_o,            // device active
  output logic            sel_start_o,           // new selection began (pulse)
  output logic            paused_o,              // pause held
  output logic            reset_mode_o,          // reset pin holding device
  input  wire logic       pin3_function_select_i,// 0 pause, 1 reset
  input  wire logic       sr_wr_i,               // status write request (pulse)
  input  wire logic [7:0] sr_wr_data_i,          // status write value
  output logic      [7:0] sr_o,                  // status register
  output logic            sr_reject_o            // protected bits refused (pulse)
);
  import sfpi_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] step_of(input logic [1:0] w);
    step_of = (w == SFPI_W_QUAD) ? 3'h4 : (w == SFPI_W_DUAL) ? 3'h2 : 3'h1;
  endfunction : step_of

  function automatic logic [3:0] oe_mask(input logic [1:0] w);
    oe_mask = (w == SFPI_W_QUAD) ? 4'hF : (w == SFPI_W_DUAL) ? 4'h3 : 4'h2;
  endfunction : oe_mask

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sck_q;
  logic [1:0] cs_q;
  logic [3:0] d_q1;
  logic [3:0] d_q2;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 3'h0;
      cs_q  <= 2'h3;
      d_q1  <= SFPI_D_IDLE;
      d_q2  <= SFPI_D_IDLE;
    end else begin
      sck_q <= {sck_q[1:0], sck_i};
      cs_q  <= {cs_q[0], cs_n_i};
      d_q1  <= data_i;
      d_q2  <= d_q1;
    end
  end

  // edges only, never levels: idle level differs between modes 0 and 3
  logic sck_rise;
  logic sck_fall;
  logic cs_s;
  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign cs_s     = cs_q[1];

  // ----------------------------------------------------------------
  // selection, pause and reset pin
  // ----------------------------------------------------------------
  logic       armed_ff;
  logic [7:0] sr_ff;
  logic       qe;
  logic       rstm;
  logic       pause;
  logic       active;

  assign qe     = sr_ff[SFPI_SR_QE];
  // quad enable takes the pin away from pause/reset
  assign rstm   = ~qe & pin3_function_select_i & ~d_q2[SFPI_L_PAUSE];
  assign pause  = ~qe & ~pin3_function_select_i & ~d_q2[SFPI_L_PAUSE]
                  & ~cs_s;
  assign active = armed_ff & ~cs_s & ~rstm;

  // ----------------------------------------------------------------
  // shift datapath
  // ----------------------------------------------------------------
  logic [2:0] rcnt_ff, nxt_rcnt;
  logic [7:0] rsh_ff, nxt_rsh;
  logic [2:0] tcnt_ff, nxt_tcnt;
  logic [7:0] tsh_ff, nxt_tsh;
  logic       drive_ff, nxt_drive;
  logic       nxt_armed, nxt_sel, nxt_start, nxt_rxv, nxt_take, nxt_rej;
  logic [7:0] nxt_rxb, nxt_sr, nxt_src;
  logic [3:0] nxt_do, nxt_oe;
  logic       nxt_pause, nxt_rstm;

  always_comb begin
    nxt_armed = rstm ? 1'b0 : (cs_s ? 1'b1 : armed_ff);
    nxt_sel   = active;
    nxt_start = active & ~selected_o;
    nxt_pause = pause;
    nxt_rstm  = rstm;
    nxt_rcnt  = rcnt_ff;
    nxt_rsh   = rsh_ff;
    nxt_rxb   = rx_byte_o;
    nxt_rxv   = 1'b0;
    nxt_tcnt  = tcnt_ff;
    nxt_tsh   = tsh_ff;
    nxt_src   = tsh_ff;
    nxt_take  = 1'b0;
    nxt_do    = data_o;
    nxt_drive = drive_ff;
    if (!active) begin
      nxt_rcnt  = SFPI_BITCNT0;
      nxt_tcnt  = SFPI_BITCNT0;
      nxt_drive = 1'b0;
    end else if (!pause) begin
      if (sck_rise) begin
        case (bus_width_i)
          SFPI_W_QUAD: nxt_rsh = {rsh_ff[3:0], d_q2};
          SFPI_W_DUAL: nxt_rsh = {rsh_ff[5:0], d_q2[1:0]};
          default:     nxt_rsh = {rsh_ff[6:0], d_q2[0]};
        endcase
        nxt_rcnt = rcnt_ff + step_of(bus_width_i);
        if (nxt_rcnt == SFPI_BITCNT0) begin
          nxt_rxb = nxt_rsh;
          nxt_rxv = 1'b1;
        end
      end
      if (sck_fall) begin
        nxt_drive = tx_drive_i;
        if (tx_drive_i) begin
          if (tcnt_ff == SFPI_BITCNT0) begin
            nxt_src  = tx_byte_i;
            nxt_take = 1'b1;
          end
          case (bus_width_i)
            SFPI_W_QUAD: nxt_do = nxt_src[7:4];
            SFPI_W_DUAL: nxt_do = {2'h0, nxt_src[7:6]};
            default:     nxt_do = {2'h0, nxt_src[7], 1'b0};
          endcase
          nxt_tsh  = nxt_src << step_of(bus_width_i);
          nxt_tcnt = tcnt_ff + step_of(bus_width_i);
        end
      end
    end
    // lines float unless read data is actually being driven
    nxt_oe = (nxt_drive & active & ~pause) ? oe_mask(bus_width_i) : 4'h0;
  end

  // ----------------------------------------------------------------
  // status register with hardware write protection
  // ----------------------------------------------------------------
  logic locked;
  // write protect pin means nothing once it carries quad data
  assign locked = sr_ff[SFPI_SR_LOCK] & ~qe & ~d_q2[SFPI_L_WP];

  always_comb begin
    nxt_sr  = sr_ff;
    nxt_rej = 1'b0;
    if (sr_wr_i) begin
      if (locked) begin
        nxt_sr  = (sr_ff & SFPI_SR_PROT) | (sr_wr_data_i & ~SFPI_SR_PROT);
        nxt_rej = 1'b1;
      end else begin
        nxt_sr  = sr_wr_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_ff     <= 1'b0;
      selected_o   <= 1'b0;
      sel_start_o  <= 1'b0;
      paused_o     <= 1'b0;
      reset_mode_o <= 1'b0;
      rcnt_ff      <= SFPI_BITCNT0;
      rsh_ff       <= 8'h00;
      rx_byte_o    <= 8'h00;
      rx_valid_o   <= 1'b0;
      tcnt_ff      <= SFPI_BITCNT0;
      tsh_ff       <= 8'h00;
      tx_take_o    <= 1'b0;
      data_o       <= 4'h0;
      data_oe_o    <= 4'h0;
      drive_ff     <= 1'b0;
      sr_ff        <= SFPI_SR_RST;
      sr_o         <= SFPI_SR_RST;
      sr_reject_o  <= 1'b0;
    end else begin
      armed_ff     <= nxt_armed;
      selected_o   <= nxt_sel;
      sel_start_o  <= nxt_start;
      paused_o     <= nxt_pause;
      reset_mode_o <= nxt_rstm;
      rcnt_ff      <= nxt_rcnt;
      rsh_ff       <= nxt_rsh;
      rx_byte_o    <= nxt_rxb;
      rx_valid_o   <= nxt_rxv;
      tcnt_ff      <= nxt_tcnt;
      tsh_ff       <= nxt_tsh;
      tx_take_o    <= nxt_take;
      data_o       <= nxt_do;
      data_oe_o    <= nxt_oe;
      drive_ff     <= nxt_drive;
      sr_ff        <= nxt_sr;
      sr_o         <= nxt_sr;
      sr_reject_o  <= nxt_rej;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  desel_float_a: assert property (cs_s |=> data_oe_o == 4'h0)
    else $error("outputs driven while deselected");
  desel_ignore_a: assert property (cs_s |=> !rx_valid_o && !tx_take_o)
    else $error("traffic taken while deselected");
  first_select_a: assert property (!armed_ff |=> !selected_o)
    else $error("selected without a prior high select");
  select_on_a: assert property (armed_ff && !cs_s && !rstm |=> selected_o)
    else $error("select low did not activate");
  rise_sample_a: assert property (rx_valid_o |-> $past(sck_rise))
    else $error("byte completed off a rising edge");
  fall_drive_a: assert property ($changed(data_o) |-> $past(sck_fall))
    else $error("output changed off a falling edge");
  quad_lines_a: assert property (data_oe_o[3] |-> $past(bus_width_i) == SFPI_W_QUAD)
    else $error("line 3 driven outside quad");
  lock_hold_a: assert property (sr_wr_i && locked |=> (sr_o & SFPI_SR_PROT) ==
                                ($past(sr_ff) & SFPI_SR_PROT) && sr_reject_o)
    else $error("protected status bits changed");
  unlock_write_a: assert property (sr_wr_i && !sr_ff[SFPI_SR_LOCK] |=>
                                   sr_o == $past(sr_wr_data_i))
    else $error("status write refused while unlocked");
  qe_no_wp_a: assert property (qe |-> !locked)
    else $error("write protect active with quad enabled");
  pause_float_a: assert property (pause |=> data_oe_o == 4'h0 && $stable(rcnt_ff))
    else $error("pause did not float and freeze");
  reset_float_a: assert property (rstm |=> data_oe_o == 4'h0 && !selected_o)
    else $error("reset pin did not float outputs");

endmodule : sfpi_pins

`default_nettype wire

//--- sfpi_pkg.sv
`default_nettype none

package sfpi_pkg;

  // ----------------------------------------------------------------
  // transfer width codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SFPI_W_SINGLE = 2'h0;
  localparam logic [1:0] SFPI_W_DUAL   = 2'h1;
  localparam logic [1:0] SFPI_W_QUAD   = 2'h2;

  // ----------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------
  localparam int         SFPI_SR_LOCK = 7;      // status_write_lock_bit
  localparam int         SFPI_SR_QE   = 6;      // quad_enable_bit
  localparam int         SFPI_SR_BP0  = 2;      // block_protect_0, _1.._3 above
  localparam logic [7:0] SFPI_SR_PROT = 8'hFC;  // lock, qe, block_protect_3..0
  localparam logic [7:0] SFPI_SR_RST  = 8'h00;

  // ----------------------------------------------------------------
  // data line indices and pin reset levels
  // ----------------------------------------------------------------
  localparam int         SFPI_L_WP    = 2;      // data_line_2 doubles as write protect
  localparam int         SFPI_L_PAUSE = 3;      // data_line_3 doubles as pause/reset
  localparam logic [3:0] SFPI_D_IDLE  = 4'hF;   // pulled-up lines
  localparam logic [2:0] SFPI_BITCNT0 = 3'h0;

endpackage : sfpi_pkg

`default_nettype wire

//--- sfpi_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sfpi_pkg::*;
  logic       clk_i, rst_i, sck_i, cs_n_i, tx_drive_i, tx_take_o, rx_valid_o, selected_o;
  logic       sel_start_o, paused_o, reset_mode_o, pin3_function_select_i, sr_wr_i, sr_reject_o;
  logic       got;
  logic [1:0] bus_width_i;
  logic [3:0] data_i, data_o, data_oe_o, h_d, h_oe, ext;
  logic [7:0] tx_byte_i, rx_byte_o, sr_wr_data_i, sr_o, rdb, sr_m, b;
  logic [7:0] rx_q[$], rd_q[$], tx_nx[$];
  logic [8:0] sr_q[$];
  int         failures, check_count, stray, seed, starts;

  sfpi_pins uut (.clk_i, .rst_i, .sck_i, .cs_n_i, .data_i, .data_o, .data_oe_o, .bus_width_i,
    .tx_drive_i, .tx_byte_i, .tx_take_o, .rx_byte_o, .rx_valid_o, .selected_o, .sel_start_o,
    .paused_o, .reset_mode_o, .pin3_function_select_i, .sr_wr_i, .sr_wr_data_i, .sr_o,
    .sr_reject_o);
  sfpi_host hst (.sck_o(sck_i), .cs_n_o(cs_n_i), .d_o(h_d), .oe_o(h_oe), .d_i(data_i),
    .got_o(got), .byte_o(rdb));

  // released lines rest on pull-ups unless ext pulls them low
  assign data_i = (data_oe_o & data_o) | (~data_oe_o & h_oe & h_d) | (~data_oe_o & ~h_oe & ext);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1 && rx_q.size() > 0) cmp("rx_byte", rx_q.pop_front(), rx_byte_o);
    else if (rx_valid_o === 1'b1) stray++;
    if (sel_start_o === 1'b1) starts++;
    if (tx_take_o === 1'b1 && tx_nx.size() > 0) tx_byte_i <= tx_nx.pop_front();
    if (sr_wr_i === 1'b1) begin
      #2 cmp("status", sr_q.pop_front(), {sr_reject_o, sr_o});
    end
  end

  always @(posedge got) cmp("read_byte", rd_q.pop_front(), rdb);

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  task automatic swr(input logic wp, input logic [7:0] d);
    logic lk;
    wt(1);
    ext[SFPI_L_WP] = wp;
    wt(4);
    sr_wr_i      = 1'b1;
    sr_wr_data_i = d;
    lk = sr_m[SFPI_SR_LOCK] && !sr_m[SFPI_SR_QE] && !wp;
    sr_m = lk ? (sr_m & SFPI_SR_PROT) | (d & ~SFPI_SR_PROT) : d;
    sr_q.push_back({lk, sr_m});
    wt(1);
    sr_wr_i = 1'b0;
  endtask : swr

  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h3b6accab;
    {rst_i, tx_drive_i, pin3_function_select_i, sr_wr_i} = 4'h8;
    {bus_width_i, tx_byte_i, sr_wr_data_i, ext} = {18'h00000, 4'hF};
    sr_m = SFPI_SR_RST;
    wt(8);
    rst_i = 1'b0;
    wt(4);
    cmp("sr_reset", {1'b0, SFPI_SR_RST}, {sr_reject_o, sr_o});
    swr(1'b0, 8'h80);
    swr(1'b0, 8'h3F);
    for (int i = 0; i < 16; i++) swr(1'($random(seed)), 8'($random(seed)));
    swr(1'b1, 8'h40);
    $display("test status done");
    for (int w = 0; w < 3; w++) begin
      for (int m = 0; m < 2; m++) begin
        bus_width_i = 2'(w);
        b = 8'($random(seed));
        rx_q.push_back(b);
        hst.frame(1'b1, 1'(m));
        cmp("selected", 9'h001, selected_o);
        hst.xfer(1 << w, 1'b0, b);
        cmp("oe_idle", 9'h000, data_oe_o);
        hst.frame(1'b0, 1'(m));
      end
    end
    $display("test write widths done");
    tx_drive_i = 1'b1;
    for (int w = 0; w < 3; w++) begin
      bus_width_i = 2'(w);
      tx_byte_i = 8'($random(seed));
      rd_q.push_back(tx_byte_i);
      tx_nx.push_back(8'($random(seed)));
      rd_q.push_back(tx_nx[0]);
      hst.frame(1'b1, 1'b1);
      hst.xfer(1 << w, 1'b1, 8'h00);
      hst.xfer(1 << w, 1'b1, 8'h00);
      hst.frame(1'b0, 1'b1);
    end
    bus_width_i = SFPI_W_SINGLE;
    wt(8);
    cmp("oe_desel", 9'h000, data_oe_o);
    stray = 0;
    hst.xfer(4, 1'b0, 8'($random(seed)));
    cmp("oe_desel", 9'h000, data_oe_o);
    tx_drive_i = 1'b0;
    $display("test read and deselect done");
    swr(1'b1, 8'h00);
    hst.frame(1'b1, 1'b0);
    ext[SFPI_L_PAUSE] = 1'b0;
    wt(6);
    cmp("paused", 9'h001, paused_o);
    hst.xfer(1, 1'b0, 8'($random(seed)));
    ext[SFPI_L_PAUSE] = 1'b1;
    wt(6);
    b = 8'($random(seed));
    rx_q.push_back(b);
    hst.xfer(1, 1'b0, b);
    hst.frame(1'b0, 1'b0);
    $display("test pause done");
    pin3_function_select_i = 1'b1;
    hst.frame(1'b1, 1'b0);
    ext[SFPI_L_PAUSE] = 1'b0;
    wt(6);
    cmp("reset_mode", 9'h020, {3'h0, reset_mode_o, selected_o, data_oe_o});
    ext[SFPI_L_PAUSE] = 1'b1;
    wt(6);
    cmp("rearm", 9'h000, selected_o);
    hst.xfer(1, 1'b0, 8'($random(seed)));
    hst.frame(1'b0, 1'b0);
    wt(8);
    cmp("stray_rx", 9'h000, 9'(stray));
    cmp("sel_starts", 9'h00B, 9'(starts));
    $display("test reset pin done");
    close_out();
  end

  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule : tb

`default_nettype wire
